// [usdp_pkg.sv]
// Package with addresses, field positions, reset values, timing and shared types of the shadow data port
package usdp_pkg;

  // Shadow bank: sixteen aliased words, the last two at their fixed addresses
  localparam logic [31:0] SHADOW_BASE     = 32'h5000_1030;
  localparam logic [31:0] SHADOW_14       = 32'h5000_1068;
  localparam logic [31:0] SHADOW_15       = 32'h5000_106C;
  localparam logic [31:0] SHADOW_LAST     = SHADOW_15;
  localparam logic [31:0] SHADOW_RESET    = 32'h0000_0000;

  // Control, line status and interrupt registers
  localparam logic [31:0] CTRL_ADDR       = 32'h5000_1100;
  localparam logic [31:0] LSTAT_ADDR      = 32'h5000_1104;
  localparam logic [31:0] ISTAT_ADDR      = 32'h5000_1108;
  localparam logic [31:0] IMASK_ADDR      = 32'h5000_110C;

  localparam int          CTRL_FIFO_EN    = 0;
  localparam int          CTRL_IR_MODE    = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam int          LSTAT_RX_VALID  = 0;
  localparam int          LSTAT_OVERRUN   = 1;
  localparam int          LSTAT_TX_EMPTY  = 5;
  localparam int          INT_RX_AVAIL    = 0;
  localparam int          INT_OVERRUN     = 1;
  localparam int          INT_TX_EMPTY    = 2;
  localparam logic [2:0]  INT_RESET       = 3'h0;

  // FIFO geometry
  localparam int          FIFO_DEPTH      = 16;
  localparam int          PTR_W           = 4;
  localparam int          CNT_W           = 5;

  // Serial timing
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          BIT_TIME_NS     = 1000;
  localparam int          BIT_CYCLES      = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int          IR_PULSE_CYCLES = (BIT_CYCLES * 3) / 16;
  localparam int          HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int          BAUD_W          = 6;
  localparam int          FRAME_BITS      = 10;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             full;
    logic             empty;
  } usdp_fifo_stat_s;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usdp_rx_state_e;

endpackage : usdp_pkg

// [usdp_fifo.sv]
// Byte FIFO with single-entry mode and optional overwrite of the newest entry when full
module usdp_fifo (
  input  wire logic                   clk,       // Clock
  input  wire logic                   rst_n,     // Asynchronous reset, active low
  input  wire logic                   flush,     // Empty the FIFO
  input  wire logic                   single,    // Hold one entry only
  input  wire logic                   push,      // Write one entry
  input  wire logic                   overwrite, // Replace newest entry when full
  input  wire logic                   pop,       // Remove head entry
  input  wire logic [7:0]             wdata,     // Entry to write
  output logic      [7:0]             rdata,     // Head entry
  output usdp_pkg::usdp_fifo_stat_s   stat,      // Level, full, empty
  output logic                        dropped    // Push lost or replaced an entry
);

  logic [7:0]                    mem [usdp_pkg::FIFO_DEPTH];
  logic [usdp_pkg::PTR_W-1:0]    wr_ptr;
  logic [usdp_pkg::PTR_W-1:0]    rd_ptr;
  logic [usdp_pkg::CNT_W-1:0]    count;
  logic [usdp_pkg::PTR_W-1:0]    next_wr_ptr;
  logic [usdp_pkg::PTR_W-1:0]    next_rd_ptr;
  logic [usdp_pkg::CNT_W-1:0]    next_count;
  logic                          full;
  logic                          empty;
  logic                          do_push;
  logic                          do_pop;
  logic                          do_over;

  assign empty   = (count == '0);
  assign full    = single ? !empty : (count == usdp_pkg::CNT_W'(usdp_pkg::FIFO_DEPTH));
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign do_over = push && full && !do_pop && overwrite;
  assign dropped = push && full && !do_pop;
  assign rdata   = mem[rd_ptr];
  assign stat    = '{count: count, full: full, empty: empty};

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else begin
      if (do_push) begin
        next_wr_ptr = wr_ptr + 1'b1;
      end
      if (do_pop) begin
        next_rd_ptr = rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        next_count = count + 1'b1;
      end else if (do_pop && !do_push) begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage has no reset; only the pointers define the contents
  always_ff @(posedge clk) begin
    if (!flush && do_push) begin
      mem[wr_ptr] <= wdata;
    end else if (!flush && do_over) begin
      mem[wr_ptr - 1'b1] <= wdata;
    end
  end

endmodule : usdp_fifo

// [usdp_shadow_port.sv]
// UART shadow receive/transmit data port: APB slave, byte FIFOs, serial and infrared framing
module usdp_shadow_port (
  input  wire logic        pclk,               // APB clock, 50 MHz
  input  wire logic        presetn,            // Asynchronous reset, active low
  input  wire logic        psel,               // APB select
  input  wire logic        penable,            // APB access phase
  input  wire logic        pwrite,             // APB direction, high for write
  input  wire logic [31:0] paddr,              // APB byte address
  input  wire logic [31:0] pwdata,             // APB write data
  output logic      [31:0] prdata,             // APB read data
  output logic             pready,             // APB ready
  output logic             pslverr,            // APB error, unmapped address
  input  wire logic        sin,                // Serial receive pin
  input  wire logic        sir_in,             // Infrared receive pin
  output logic             sout,               // Serial transmit pin
  output logic             sir_out_n,          // Infrared transmit pin, active low
  output logic             rx_valid_flag,      // Receive data ready
  output logic             tx_hold_empty_flag, // Transmit holding empty
  output logic             irq                 // Interrupt, active high level
);

  localparam logic [usdp_pkg::BAUD_W-1:0] BIT_LAST  = usdp_pkg::BAUD_W'(usdp_pkg::BIT_CYCLES - 1);
  localparam logic [usdp_pkg::BAUD_W-1:0] HALF_LAST = usdp_pkg::BAUD_W'(usdp_pkg::HALF_BIT_CYCLES - 1);
  localparam logic [usdp_pkg::BAUD_W-1:0] IR_PULSE  = usdp_pkg::BAUD_W'(usdp_pkg::IR_PULSE_CYCLES);

  // Register state
  logic [1:0]                  ctrl;
  logic [2:0]                  istat;
  logic [2:0]                  imask;
  logic                        overrun;
  logic [1:0]                  next_ctrl;
  logic [2:0]                  next_istat;
  logic [2:0]                  next_imask;
  logic                        next_overrun;
  logic [31:0]                 next_prdata;
  logic                        next_pready;
  logic                        next_pslverr;
  logic                        next_irq;
  logic                        next_rx_valid;
  logic                        next_tx_empty;

  // Bus decode
  logic                        setup;
  logic                        access;
  logic                        hit_shadow;
  logic                        hit_ctrl;
  logic                        hit_lstat;
  logic                        hit_istat;
  logic                        hit_imask;
  logic                        mapped;
  logic                        fifo_en;
  logic                        ir_mode;
  logic                        flush;

  // FIFOs
  logic [7:0]                  rx_head;
  logic [7:0]                  tx_head;
  usdp_pkg::usdp_fifo_stat_s   rx_stat;
  usdp_pkg::usdp_fifo_stat_s   tx_stat;
  logic                        rx_push;
  logic                        rx_pop;
  logic                        rx_lost;
  logic                        tx_push;
  logic                        tx_pop;

  // Serial state
  logic [1:0]                  sin_meta;
  logic [1:0]                  sin_sync;
  logic                        rx_line;
  usdp_pkg::usdp_rx_state_e    rx_state;
  usdp_pkg::usdp_rx_state_e    next_rx_state;
  logic [usdp_pkg::BAUD_W-1:0] rx_cnt;
  logic [usdp_pkg::BAUD_W-1:0] next_rx_cnt;
  logic [2:0]                  rx_bit;
  logic [2:0]                  next_rx_bit;
  logic [7:0]                  rx_shift;
  logic [7:0]                  next_rx_shift;
  logic                        tx_busy;
  logic                        next_tx_busy;
  logic [9:0]                  tx_shift;
  logic [9:0]                  next_tx_shift;
  logic [3:0]                  tx_bit;
  logic [3:0]                  next_tx_bit;
  logic [usdp_pkg::BAUD_W-1:0] tx_cnt;
  logic [usdp_pkg::BAUD_W-1:0] next_tx_cnt;
  logic                        next_sout;
  logic                        next_sir_out_n;

  assign fifo_en    = ctrl[usdp_pkg::CTRL_FIFO_EN];
  assign ir_mode    = ctrl[usdp_pkg::CTRL_IR_MODE];
  assign setup      = psel && !penable;
  assign access     = psel && penable && pready;
  assign hit_shadow = (paddr >= usdp_pkg::SHADOW_BASE) && (paddr <= usdp_pkg::SHADOW_LAST)
                      && (paddr[1:0] == 2'h0);
  assign hit_ctrl   = (paddr == usdp_pkg::CTRL_ADDR);
  assign hit_lstat  = (paddr == usdp_pkg::LSTAT_ADDR);
  assign hit_istat  = (paddr == usdp_pkg::ISTAT_ADDR);
  assign hit_imask  = (paddr == usdp_pkg::IMASK_ADDR);
  assign mapped     = hit_shadow || hit_ctrl || hit_lstat || hit_istat || hit_imask;
  // Pop only when the setup cycle saw data, so a byte landing mid-transfer is not lost
  assign rx_pop     = access && !pwrite && hit_shadow && rx_valid_flag;
  assign tx_push    = access && pwrite && hit_shadow;
  // Changing the FIFO mode empties both queues
  assign flush      = access && pwrite && hit_ctrl && (pwdata[usdp_pkg::CTRL_FIFO_EN] != fifo_en);

  usdp_fifo u_rx_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .flush     (flush),
    .single    (!fifo_en),
    .push      (rx_push),
    .overwrite (!fifo_en),
    .pop       (rx_pop),
    .wdata     (rx_shift),
    .rdata     (rx_head),
    .stat      (rx_stat),
    .dropped   (rx_lost)
  );

  usdp_fifo u_tx_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .flush     (flush),
    .single    (!fifo_en),
    .push      (tx_push),
    .overwrite (!fifo_en),
    .pop       (tx_pop),
    .wdata     (pwdata[7:0]),
    .rdata     (tx_head),
    .stat      (tx_stat),
    .dropped   ()
  );

  // Registers and APB answer
  always_comb begin
    next_ctrl     = ctrl;
    next_imask    = imask;
    next_istat    = istat;
    next_overrun  = overrun;
    next_prdata   = prdata;
    next_pready   = setup;
    next_pslverr  = setup && !mapped;
    if (setup && !pwrite) begin
      next_prdata = 32'h0000_0000;
      if (hit_shadow) begin
        next_prdata[7:0] = rx_stat.empty ? 8'h00 : rx_head;
      end else if (hit_ctrl) begin
        next_prdata[1:0] = ctrl;
      end else if (hit_lstat) begin
        next_prdata[usdp_pkg::LSTAT_RX_VALID] = !rx_stat.empty;
        next_prdata[usdp_pkg::LSTAT_OVERRUN]  = overrun;
        next_prdata[usdp_pkg::LSTAT_TX_EMPTY] = tx_stat.empty;
      end else if (hit_istat) begin
        next_prdata[2:0] = istat;
      end else if (hit_imask) begin
        next_prdata[2:0] = imask;
      end
    end
    if (access && pwrite && hit_ctrl) begin
      next_ctrl = pwdata[1:0];
    end
    if (access && pwrite && hit_imask) begin
      next_imask = pwdata[2:0];
    end
    // Clear only what the read reported, so an event landing after setup survives
    if (access && !pwrite && hit_istat) begin
      next_istat = istat & ~prdata[2:0];
    end
    if (access && !pwrite && hit_lstat) begin
      next_overrun = overrun && !prdata[usdp_pkg::LSTAT_OVERRUN];
    end
    // Events set after the clears so a coincident event is kept
    if (rx_push) begin
      next_istat[usdp_pkg::INT_RX_AVAIL] = 1'b1;
    end
    if (rx_push && rx_lost) begin
      next_overrun                      = 1'b1;
      next_istat[usdp_pkg::INT_OVERRUN] = 1'b1;
    end
    if (tx_pop && tx_stat.count == usdp_pkg::CNT_W'(1) && !tx_push) begin
      next_istat[usdp_pkg::INT_TX_EMPTY] = 1'b1;
    end
    next_irq      = |(next_istat & next_imask);
    next_rx_valid = !rx_stat.empty;
    next_tx_empty = tx_stat.empty;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl               <= usdp_pkg::CTRL_RESET;
      imask              <= usdp_pkg::INT_RESET;
      istat              <= usdp_pkg::INT_RESET;
      overrun            <= 1'b0;
      prdata             <= usdp_pkg::SHADOW_RESET;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
      irq                <= 1'b0;
      rx_valid_flag      <= 1'b0;
      tx_hold_empty_flag <= 1'b1;
    end else begin
      ctrl               <= next_ctrl;
      imask              <= next_imask;
      istat              <= next_istat;
      overrun            <= next_overrun;
      prdata             <= next_prdata;
      pready             <= next_pready;
      pslverr            <= next_pslverr;
      irq                <= next_irq;
      rx_valid_flag      <= next_rx_valid;
      tx_hold_empty_flag <= next_tx_empty;
    end
  end

  // Receiver: line chosen by mode after two-stage synchronisers
  assign rx_line = ir_mode ? sin_sync[1] : sin_sync[0];
  assign rx_push = (rx_state == usdp_pkg::RX_STOP) && (rx_cnt == BIT_LAST) && rx_line;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt   = rx_cnt + 1'b1;
    next_rx_bit   = rx_bit;
    next_rx_shift = rx_shift;
    case (rx_state)
      usdp_pkg::RX_IDLE: begin
        next_rx_cnt = '0;
        if (!rx_line) begin
          next_rx_state = usdp_pkg::RX_START;
        end
      end
      usdp_pkg::RX_START: begin
        if (rx_cnt == HALF_LAST) begin
          next_rx_cnt   = '0;
          next_rx_bit   = 3'h0;
          next_rx_state = rx_line ? usdp_pkg::RX_IDLE : usdp_pkg::RX_DATA;
        end
      end
      usdp_pkg::RX_DATA: begin
        if (rx_cnt == BIT_LAST) begin
          next_rx_cnt   = '0;
          next_rx_shift = {rx_line, rx_shift[7:1]};
          next_rx_bit   = rx_bit + 1'b1;
          if (rx_bit == 3'h7) begin
            next_rx_state = usdp_pkg::RX_STOP;
          end
        end
      end
      usdp_pkg::RX_STOP: begin
        if (rx_cnt == BIT_LAST) begin
          next_rx_state = usdp_pkg::RX_IDLE;
        end
      end
      default: begin
        next_rx_state = usdp_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_meta <= 2'h3;
      sin_sync <= 2'h3;
      rx_state <= usdp_pkg::RX_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
    end else begin
      sin_meta <= {sir_in, sin};
      sin_sync <= sin_meta;
      rx_state <= next_rx_state;
      rx_cnt   <= next_rx_cnt;
      rx_bit   <= next_rx_bit;
      rx_shift <= next_rx_shift;
    end
  end

  // Transmitter: start, eight data bits LSB first, stop
  assign tx_pop       = !tx_busy && !tx_stat.empty;

  always_comb begin
    next_tx_busy   = tx_busy;
    next_tx_shift  = tx_shift;
    next_tx_bit    = tx_bit;
    next_tx_cnt    = tx_cnt;
    if (tx_pop) begin
      next_tx_busy  = 1'b1;
      next_tx_shift = {1'b1, tx_head, 1'b0};
      next_tx_bit   = 4'h0;
      next_tx_cnt   = '0;
    end else if (tx_busy) begin
      next_tx_cnt = tx_cnt + 1'b1;
      if (tx_cnt == BIT_LAST) begin
        next_tx_cnt   = '0;
        next_tx_shift = {1'b1, tx_shift[9:1]};
        next_tx_bit   = tx_bit + 1'b1;
        if (tx_bit == 4'(usdp_pkg::FRAME_BITS - 1)) begin
          next_tx_busy = 1'b0;
        end
      end
    end
    next_sout      = (next_tx_busy && !ir_mode) ? next_tx_shift[0] : 1'b1;
    next_sir_out_n = !(next_tx_busy && ir_mode && !next_tx_shift[0] && next_tx_cnt < IR_PULSE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy   <= 1'b0;
      tx_shift  <= 10'h3FF;
      tx_bit    <= 4'h0;
      tx_cnt    <= '0;
      sout      <= 1'b1;
      sir_out_n <= 1'b1;
    end else begin
      tx_busy   <= next_tx_busy;
      tx_shift  <= next_tx_shift;
      tx_bit    <= next_tx_bit;
      tx_cnt    <= next_tx_cnt;
      sout      <= next_sout;
      sir_out_n <= next_sir_out_n;
    end
  end

endmodule : usdp_shadow_port

// [usdp_shadow_port_assertions.sv]
// Port-level checks of the shadow data port, bound into the design
module usdp_shadow_port_checker (
  input wire logic        pclk,               // Clock
  input wire logic        presetn,            // Reset, active low
  input wire logic        psel,               // APB select
  input wire logic        penable,            // APB access phase
  input wire logic        pwrite,             // APB direction
  input wire logic [31:0] paddr,              // APB address
  input wire logic [31:0] prdata,             // APB read data
  input wire logic        pready,             // APB ready
  input wire logic        pslverr,            // APB error
  input wire logic        sout,               // Serial output
  input wire logic        sir_out_n,          // Infrared output
  input wire logic        tx_hold_empty_flag  // Transmit holding empty
);
  timeunit 1ns;
  timeprecision 1ns;
  logic shad;
  assign shad = paddr >= usdp_pkg::SHADOW_BASE && paddr <= usdp_pkg::SHADOW_LAST && paddr[1:0] == 2'h0;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_pready_one: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_ready_cause: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("ready without setup");
  a_hold_clear: assert property (psel && penable && pready && pwrite && shad |-> ##[1:2] !tx_hold_empty_flag)
    else $error("holding empty not cleared by write");
  a_read_upper: assert property (pready && !pwrite && shad |-> prdata[31:8] == 24'h0)
    else $error("reserved read bits not zero");
  a_ir_pulse: assert property ($fell(sir_out_n) |=> !sir_out_n [*8] ##1 sir_out_n)
    else $error("infrared pulse length wrong");
  a_one_output: assert property (!sir_out_n |-> sout)
    else $error("both outputs active");
  a_start_low: assert property ($fell(sout) |=> !sout [*8])
    else $error("start bit too short");
endmodule : usdp_shadow_port_checker

bind usdp_shadow_port usdp_shadow_port_checker i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .sout, .sir_out_n, .tx_hold_empty_flag
);

// [usdp_remote_uart.sv]
// Remote serial device: sends frames into the port and collects the frames it transmits
module usdp_remote_uart (
  input  wire logic pclk,      // Clock
  input  wire logic ir,        // Infrared mode selected
  input  wire logic sout,      // Port serial output
  input  wire logic sir_out_n, // Port infrared output
  output logic      sin,       // Serial line to the port
  output logic      sir_in     // Infrared line to the port
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = usdp_pkg::BIT_CYCLES;
  logic [7:0] got[$];
  logic [7:0] b;
  logic       ln;
  assign ln = ir ? sir_out_n : sout;
  initial begin
    sin = 1'b1;
    sir_in = 1'b1;
  end
  task send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (ir) sir_in <= f[i];
      else sin <= f[i];
      repeat (BIT) @(posedge pclk);
    end
  endtask : send
  // Infrared zero bits are short low pulses at the bit start, so sample early
  initial forever begin
    @(negedge ln);
    repeat (ir ? 4 : BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      b[i] = ln;
    end
    repeat (BIT) @(posedge pclk);
    got.push_back(b);
  end
endmodule : usdp_remote_uart

// [usdp_shadow_port_tb.sv]
// Self-checking bench of the shadow data port over APB with a remote serial device
module usdp_shadow_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] SH  = usdp_pkg::SHADOW_BASE;
  localparam logic [31:0] LST = usdp_pkg::LSTAT_ADDR;
  localparam logic [31:0] IST = usdp_pkg::ISTAT_ADDR;
  localparam logic [31:0] MSK = usdp_pkg::IMASK_ADDR;
  logic        pclk, presetn, psel, penable, pwrite, ir, e;
  logic [31:0] paddr, pwdata, prdata, r;
  logic        pready, pslverr, sin, sir_in, sout, sir_out_n;
  logic        rx_valid_flag, tx_hold_empty_flag, irq;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  `define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin fails++; \
    $display("unexpected at %0t: got %0h, expected %0h", $time, (g), (x)); end end

  usdp_shadow_port i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sin, .sir_in, .sout, .sir_out_n, .rx_valid_flag, .tx_hold_empty_flag, .irq
  );
  usdp_remote_uart i_far (.pclk, .ir, .sout, .sir_out_n, .sin, .sir_in);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task print_verdict;
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      print_verdict();
    end
  end

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [31:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task rdc(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(r, x)
  endtask : rdc

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ir = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(usdp_pkg::SHADOW_14, 32'h0);
    rdc(LST, 32'h20);
    apb(1'b0, 32'h5000_1200, 32'h0);
    `CHK(e, 1'b1)
    // Masked receive event, then an unread byte overwritten
    wr(MSK, 8'h02);
    i_far.send(8'hA5);
    repeat (10) @(posedge pclk);
    `CHK(irq, 1'b0)
    `CHK(rx_valid_flag, 1'b1)
    rdc(IST, 32'h1);
    i_far.send(8'h3C);
    repeat (10) @(posedge pclk);
    `CHK(irq, 1'b1)
    rdc(LST, 32'h23);
    rdc(IST, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    rdc(usdp_pkg::SHADOW_15, 32'h3C);
    repeat (2) @(posedge pclk);
    `CHK(rx_valid_flag, 1'b0)
    // Held byte replaced while the shifter is busy
    `CHK(tx_hold_empty_flag, 1'b1)
    wr(SH, 8'h11);
    wr(SH + 32'h4, 8'h22);
    repeat (2) @(posedge pclk);
    `CHK(tx_hold_empty_flag, 1'b0)
    wr(SH + 32'h8, 8'h33);
    repeat (1100) @(posedge pclk);
    `CHK(i_far.got.size(), 2)
    `CHK(i_far.got[0], 8'h11)
    `CHK(i_far.got[1], 8'h33)
    // FIFO mode: seventeen arrivals into sixteen places
    wr(usdp_pkg::CTRL_ADDR, 8'h01);
    for (int i = 0; i < 17; i++) i_far.send(8'h40 + 8'(i));
    repeat (10) @(posedge pclk);
    rdc(LST, 32'h23);
    for (int i = 0; i < 16; i++) rdc(SH + 32'(4 * i), 32'h40 + 32'(i));
    rdc(SH, 32'h0);
    // One byte to the shifter, sixteen fill the FIFO, the last is lost
    i_far.got.delete();
    for (int i = 0; i < 18; i++) wr(SH + 32'(4 * (i % 16)), 8'h80 + 8'(i));
    repeat (8700) @(posedge pclk);
    `CHK(i_far.got.size(), 17)
    for (int i = 0; i < 17; i++) `CHK(i_far.got[i], 8'h80 + 8'(i))
    wr(MSK, 8'h04);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    rdc(IST, 32'h7);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    // Infrared path in both directions
    wr(usdp_pkg::CTRL_ADDR, 8'h02);
    ir <= 1'b1;
    @(posedge pclk);
    i_far.got.delete();
    i_far.send(8'h5A);
    repeat (10) @(posedge pclk);
    rdc(usdp_pkg::SHADOW_14, 32'h5A);
    wr(usdp_pkg::SHADOW_15, 8'hC3);
    repeat (560) @(posedge pclk);
    `CHK(i_far.got[0], 8'hC3)
    print_verdict();
  end
endmodule : usdp_shadow_port_tb
